/* File: rls_status_bank.sv */
// Paged per-receive-port status registers with clear-on-read event flags
//
// Overview of operation
// [RL1] Status accesses go to the bank of the port chosen by bank select.
// [RL2] First status bit 6 returns the selected read port number.
// [RL3] Control channel checksum error sets bit 5; cleared by reading.
// [RL4] Any lock state change since last read sets bit 4; cleared by reading.
// [RL5] Control channel order error sets bit 3; cleared by reading.
// [RL6] Bit 2 is high while parity count exceeds limit; clears with counters.
// [RL7] Bit 1 shows the live receiver pass indication.
// [RL8] Bit 0 shows the live receiver lock state.
// [RL9] Second status bit 7 latches unequal line widths until read.
// [RL10] Line width change sets second status bit 6; cleared by reading.
// [RL11] Link coding fault sets second status bit 5; cleared by reading.
// [RL12] Host enables link error counting with limit above 1 before trusting bit 5.
// [RL13] Packet buffer overflow sets second status bit 4; cleared by reading.
// [RL14] Second status bit 3 summarises camera receive faults, read-only.
// [RL15] Second status bit 1 reports cable open or short, read-only.
// [RL16] Row count change sets second status bit 0; cleared by reading.
// [RL17] One read-port bit in bank select picks port 0 or port 1.
// [RL18] Parity counters clear on low byte read and on fresh lock.
// [RL19] A set in the same cycle as the clearing read wins.
// [RL20] Reserved bit 7 reads zero; writes to status registers are ignored.
module rls_status_bank #(
    parameter int NPORT = rls_pkg::RLS_NPORT,
    parameter int PCNT_W = rls_pkg::RLS_PCNT_W
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire rls_pkg::rls_evt_t [NPORT-1:0] EVT_I,
    input wire logic [NPORT-1:0][PCNT_W-1:0] PAR_LIMIT_I,
    output logic [7:0] RDATA_O,
    output logic RVALID_O,
    output logic RD_PORT_O,
    output logic [1:0] WR_EN_O
);
    import rls_pkg::*;

    logic rd_port_r;
    logic [1:0] wr_en_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [NPORT-1:0][7:0] sticky_one_r;
    logic [NPORT-1:0][7:0] sticky_two_r;
    logic [NPORT-1:0] lock_prev_r;
    logic [NPORT-1:0][PCNT_W-1:0] pcnt_r;

    logic [NPORT-1:0][7:0] set_one;
    logic [NPORT-1:0][7:0] set_two;
    logic [NPORT-1:0][7:0] status_one;
    logic [NPORT-1:0][7:0] status_two;
    logic [NPORT-1:0] par_over;
    logic [NPORT-1:0] lock_rise;

    wire hit_select = ADDR_I == ADDR_BANK_SELECT;
    wire hit_one = ADDR_I == ADDR_STATUS_ONE;
    wire hit_two = ADDR_I == ADDR_STATUS_TWO;
    wire hit_phigh = ADDR_I == ADDR_PARITY_HIGH;
    wire hit_plow = ADDR_I == ADDR_PARITY_LOW;
    // Only the bank select register accepts writes here
    wire wr_select = WR_I && hit_select; // see [RL20]
    wire [7:0] select_view = {1'b0, 1'b0, 1'b0, rd_port_r, 2'b00, wr_en_r}; // see [RL17]

    genvar p;
    generate
        for (p = 0; p < NPORT; p++)
        begin : g_port
            wire mine = rd_port_r == p[0]; // see [RL1]
            wire clr_one = RD_I && hit_one && mine;
            wire clr_two = RD_I && hit_two && mine;
            wire clr_pcnt = (RD_I && hit_plow && mine) || lock_rise[p]; // see [RL18]
            wire pcnt_full = &pcnt_r[p];
            wire [PCNT_W-1:0] pcnt_inc = pcnt_full ? pcnt_r[p] : pcnt_r[p] + 1'b1;
            wire [PCNT_W-1:0] pcnt_base = clr_pcnt ? PCNT_RESET : pcnt_r[p];
            wire [PCNT_W-1:0] pcnt_base_inc = clr_pcnt ? {{(PCNT_W-1){1'b0}}, 1'b1} : pcnt_inc;
            wire [PCNT_W-1:0] pcnt_nxt = EVT_I[p].parity_evt ? pcnt_base_inc : pcnt_base;
            wire [7:0] one_nxt = set_one[p] | (sticky_one_r[p] & ~(clr_one ? STICKY_ONE_MASK : 8'h00)); // see [RL19]
            wire [7:0] two_nxt = set_two[p] | (sticky_two_r[p] & ~(clr_two ? STICKY_TWO_MASK : 8'h00)); // see [RL19]

            assign lock_rise[p] = EVT_I[p].receiver_locked && !lock_prev_r[p];
            assign par_over[p] = pcnt_r[p] > PAR_LIMIT_I[p]; // see [RL6]

            assign set_one[p] = (8'(EVT_I[p].ctrl_crc_evt) << S1_CHECKSUM) // see [RL3]
                | (8'(EVT_I[p].receiver_locked ^ lock_prev_r[p]) << S1_LOCK_CHG) // see [RL4]
                | (8'(EVT_I[p].ctrl_order_evt) << S1_ORDER); // see [RL5]
            // Coding faults are only seen if lock survives them; host sets the limit, see [RL12]
            assign set_two[p] = (8'(EVT_I[p].width_irregular_evt) << S2_WIDTH_IRREG) // see [RL9]
                | (8'(EVT_I[p].width_changed_evt) << S2_WIDTH_CHG) // see [RL10]
                | (8'(EVT_I[p].coding_fault_evt) << S2_CODING) // see [RL11]
                | (8'(EVT_I[p].buffer_overflow_evt) << S2_BUFFER) // see [RL13]
                | (8'(EVT_I[p].rows_changed_evt) << S2_ROWS_CHG); // see [RL16]

            assign status_one[p] = (sticky_one_r[p] & STICKY_ONE_MASK)
                | (8'(rd_port_r) << S1_PORT_NUM) // see [RL2]
                | (8'(par_over[p]) << S1_PARITY) // see [RL6]
                | (8'(EVT_I[p].port_pass) << S1_PASS) // see [RL7]
                | (8'(EVT_I[p].receiver_locked) << S1_LOCKED); // see [RL8]
            assign status_two[p] = (sticky_two_r[p] & STICKY_TWO_MASK)
                | (8'(EVT_I[p].camera_rx_fault) << S2_CAMERA) // see [RL14]
                | (8'(EVT_I[p].rate_measure_settled) << S2_RATE)
                | (8'(EVT_I[p].cable_fault) << S2_CABLE); // see [RL15]

            always_ff @(posedge CLK_I or posedge RESET_I)
            begin
                if (RESET_I)
                begin
                    sticky_one_r[p] <= STATUS_RESET;
                    sticky_two_r[p] <= STATUS_RESET;
                    lock_prev_r[p] <= 1'b0;
                    pcnt_r[p] <= PCNT_RESET;
                end
                else
                begin
                    sticky_one_r[p] <= one_nxt;
                    sticky_two_r[p] <= two_nxt;
                    lock_prev_r[p] <= EVT_I[p].receiver_locked;
                    pcnt_r[p] <= pcnt_nxt;
                end
            end
        end
    endgenerate

    // Unmapped addresses read as zero; bit 7 of the first status never set, see [RL20]
    wire [PCNT_W-1:0] pcnt_sel = pcnt_r[rd_port_r];
    wire [7:0] rdata_nxt = hit_select ? select_view
        : hit_one ? status_one[rd_port_r] // see [RL1]
        : hit_two ? status_two[rd_port_r]
        : hit_phigh ? pcnt_sel[15:8]
        : hit_plow ? pcnt_sel[7:0]
        : 8'h00;

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            rd_port_r <= RD_PORT_RESET;
            wr_en_r <= WR_EN_RESET;
            rdata_r <= RDATA_RESET;
            rvalid_r <= 1'b0;
        end
        else
        begin
            if (wr_select)
            begin
                rd_port_r <= WDATA_I[SEL_READ_PORT]; // see [RL17]
                wr_en_r <= WDATA_I[SEL_WRITE_EN_LSB +: 2];
            end
            if (RD_I)
            begin
                rdata_r <= rdata_nxt;
            end
            rvalid_r <= RD_I;
        end
    end

    assign RDATA_O = rdata_r;
    assign RVALID_O = rvalid_r;
    assign RD_PORT_O = rd_port_r;
    assign WR_EN_O = wr_en_r;

endmodule : rls_status_bank

/* File: rls_pkg.sv */
// Constants, field positions and carrier types for the receive-port status bank
package rls_pkg;

    localparam int RLS_NPORT = 2;
    localparam int RLS_PCNT_W = 16;

    // Register addresses
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h4C;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h4D;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h4E;
    localparam logic [7:0] ADDR_PARITY_HIGH = 8'h55;
    localparam logic [7:0] ADDR_PARITY_LOW = 8'h56;

    // Bank select fields
    localparam int SEL_PHYS_PORT = 6;
    localparam int SEL_READ_PORT = 4;
    localparam int SEL_WRITE_EN_LSB = 0;

    // First status register fields
    localparam int S1_PORT_NUM = 6;
    localparam int S1_CHECKSUM = 5;
    localparam int S1_LOCK_CHG = 4;
    localparam int S1_ORDER = 3;
    localparam int S1_PARITY = 2;
    localparam int S1_PASS = 1;
    localparam int S1_LOCKED = 0;

    // Second status register fields
    localparam int S2_WIDTH_IRREG = 7;
    localparam int S2_WIDTH_CHG = 6;
    localparam int S2_CODING = 5;
    localparam int S2_BUFFER = 4;
    localparam int S2_CAMERA = 3;
    localparam int S2_RATE = 2;
    localparam int S2_CABLE = 1;
    localparam int S2_ROWS_CHG = 0;

    // Clear-on-read bit groups
    localparam logic [7:0] STICKY_ONE_MASK = 8'h38;
    localparam logic [7:0] STICKY_TWO_MASK = 8'hF1;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic RD_PORT_RESET = 1'b0;
    localparam logic [1:0] WR_EN_RESET = 2'b00;
    localparam logic [RLS_PCNT_W-1:0] PCNT_RESET = 16'h0000;

    // Per-port status and event inputs from the link receiver
    typedef struct packed {
        logic receiver_locked;
        logic port_pass;
        logic ctrl_crc_evt;
        logic ctrl_order_evt;
        logic parity_evt;
        logic width_irregular_evt;
        logic width_changed_evt;
        logic coding_fault_evt;
        logic buffer_overflow_evt;
        logic camera_rx_fault;
        logic rate_measure_settled;
        logic cable_fault;
        logic rows_changed_evt;
    } rls_evt_t;

endpackage : rls_pkg

/* File: rls_chk.sv */
// Port-level assertions for the receive-port status bank
module rls_chk
    import rls_pkg::*;
#(
    parameter int NPORT = 2,
    parameter int PCNT_W = 16
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire rls_pkg::rls_evt_t [NPORT-1:0] EVT_I,
    input wire logic [NPORT-1:0][PCNT_W-1:0] PAR_LIMIT_I,
    input wire logic [7:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic RD_PORT_O,
    input wire logic [1:0] WR_EN_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    wire rd1 = RD_I && ADDR_I == ADDR_STATUS_ONE;
    wire rd2 = RD_I && ADDR_I == ADDR_STATUS_TWO;
    rls_evt_t ev;
    assign ev = EVT_I[RD_PORT_O];
    a_read_answer: assert property (RD_I |=> RVALID_O)
        else $error("read strobe not answered");
    a_rsvd_zero: assert property (rd1 |=> !RDATA_O[7])
        else $error("reserved bit not zero");
    a_port_shown: assert property (rd1 |=> RDATA_O[S1_PORT_NUM] == $past(RD_PORT_O))
        else $error("port number wrong");
    a_lock_live: assert property (rd1 |=> RDATA_O[S1_LOCKED] == $past(ev.receiver_locked))
        else $error("lock bit wrong");
    a_pass_live: assert property (rd1 |=> RDATA_O[S1_PASS] == $past(ev.port_pass))
        else $error("pass bit wrong");
    a_cable_live: assert property (rd2 |=> RDATA_O[S2_CABLE] == $past(ev.cable_fault))
        else $error("cable bit wrong");
    a_port_select: assert property (WR_I && ADDR_I == ADDR_BANK_SELECT
        |=> RD_PORT_O == $past(WDATA_I[SEL_READ_PORT]))
        else $error("read port not stored");
    a_crc_clears: assert property (rd1 && !WR_I && !ev.ctrl_crc_evt ##1 rd1 && !ev.ctrl_crc_evt
        |=> !RDATA_O[S1_CHECKSUM])
        else $error("checksum flag not cleared");
    a_set_wins: assert property (rd1 && !WR_I && ev.ctrl_order_evt ##1 rd1 |=> RDATA_O[S1_ORDER])
        else $error("event lost at read");
    cover property (rd2);
    cover property (WR_I && ADDR_I == ADDR_BANK_SELECT ##1 rd1);
    cover property (rd1 ##1 rd1);
endmodule : rls_chk

bind rls_status_bank rls_chk #(.NPORT(NPORT), .PCNT_W(PCNT_W)) i_rls_chk (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .EVT_I(EVT_I), .PAR_LIMIT_I(PAR_LIMIT_I), .RDATA_O(RDATA_O),
    .RVALID_O(RVALID_O), .RD_PORT_O(RD_PORT_O), .WR_EN_O(WR_EN_O));

/* File: rls_host.sv */
// Host model issuing byte reads and writes to the status bank
module rls_host (
    input wire logic CLK_I,
    input wire logic RVALID_I,
    input wire logic [7:0] RDATA_I,
    output logic [7:0] ADDR_O,
    output logic [7:0] WDATA_O,
    output logic WR_O,
    output logic RD_O
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ADDR_O, WDATA_O, WR_O, RD_O} = '0;
    // Coding flag only trusted once fault counting runs with a limit above 1
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        {ADDR_O, WDATA_O, WR_O} <= {a, d, 1'b1};
        @(posedge CLK_I);
        WR_O <= 1'b0;
    endtask : wr
    // n back-to-back strobes; d answers the last one
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d, output bit ok);
        {ok, d} = '0;
        @(posedge CLK_I);
        {ADDR_O, RD_O} <= {a, 1'b1};
        repeat (n) @(posedge CLK_I);
        RD_O <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(posedge CLK_I);
            if (RVALID_I === 1'b1) {ok, d} = {1'b1, RDATA_I};
        end
    endtask : rd
endmodule : rls_host

/* File: rls_status_bank_test.sv */
// Self-checking bench for the receive-port status bank
module rls_status_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rls_pkg::*;
    typedef struct packed {logic [12:0] e; logic [7:0] a; logic [7:0] x;} rls_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid, rport;
    logic [1:0] wen;
    rls_evt_t [1:0] evt = '0;
    logic [1:0][15:0] lim = {16'h0001, 16'h0001};
    int n_fail = 0;
    int n_compared = 0;
    rls_row_t rows [12] = '{'{13'h0400, 8'h4D, 8'h20}, '{13'h0200, 8'h4D, 8'h08},
        '{13'h0800, 8'h4D, 8'h02}, '{13'h0080, 8'h4E, 8'h80}, '{13'h0040, 8'h4E, 8'h40},
        '{13'h0020, 8'h4E, 8'h20}, '{13'h0010, 8'h4E, 8'h10}, '{13'h0008, 8'h4E, 8'h08},
        '{13'h0002, 8'h4E, 8'h02}, '{13'h0001, 8'h4E, 8'h01}, '{13'h0004, 8'h4E, 8'h04},
        '{13'h0000, 8'h00, 8'h00}};
    always #2 clk = ~clk;
    rls_status_bank i_rls_status_bank (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .EVT_I(evt), .PAR_LIMIT_I(lim),
        .RDATA_O(rdata), .RVALID_O(rvalid), .RD_PORT_O(rport), .WR_EN_O(wen));
    rls_host i_rls_host (.CLK_I(clk), .RVALID_I(rvalid), .RDATA_I(rdata), .ADDR_O(addr),
        .WDATA_O(wdata), .WR_O(wr), .RD_O(rd));
    task automatic results;
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        n_compared++;
        if (g !== x)
        begin
            $display("BAD %s exp %h got %h", s, x, g);
            n_fail++;
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input int n, input logic [7:0] x, input string s);
        logic [7:0] d;
        bit ok;
        i_rls_host.rd(a, n, d, ok);
        if (!ok)
        begin
            n_fail++;
            results();
        end
        else
            chk(s, x, d);
    endtask : rc
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc(8'h4D, 1, 8'h00, "status one");
        rc(8'h4E, 1, 8'h00, "status two");
        foreach (rows[i])
        begin
            @(posedge clk);
            evt[0] <= rls_evt_t'(rows[i].e);
            @(posedge clk);
            evt[0] <= rls_evt_t'(rows[i].e & 13'h180E);
            rc(rows[i].a, 1, rows[i].x, "table row");
            evt[0] <= '0;
        end
        // Let an edge pass so the stimulus is not assigned twice in one step
        @(posedge clk);
        {evt[0].ctrl_crc_evt, evt[1].ctrl_crc_evt} <= 2'b11;
        @(posedge clk);
        evt <= '0;
        i_rls_host.wr(8'h4D, 8'hFF);
        i_rls_host.wr(8'h4C, 8'h13);
        @(posedge clk);
        chk("read port", 8'h01, {7'h00, rport});
        chk("write enables", 8'h03, {6'h00, wen});
        rc(8'h4C, 1, 8'h13, "bank select");
        rc(8'h4D, 1, 8'h60, "port one");
        i_rls_host.wr(8'h4C, 8'h00);
        rc(8'h4D, 1, 8'h20, "port zero");
        fork
            rc(8'h4D, 2, 8'h08, "set wins");
            begin
                @(posedge clk);
                evt[0].ctrl_order_evt <= 1'b1;
                @(posedge clk);
                evt[0] <= '0;
            end
        join
        evt[0].receiver_locked <= 1'b1;
        rc(8'h4D, 1, 8'h11, "lock rise");
        rc(8'h4D, 1, 8'h01, "lock held");
        evt[0].receiver_locked <= 1'b0;
        rc(8'h4D, 1, 8'h10, "lock fall");
        evt[0].parity_evt <= 1'b1;
        repeat (2) @(posedge clk);
        evt[0].parity_evt <= 1'b0;
        rc(8'h4D, 1, 8'h04, "parity over");
        rc(8'h55, 1, 8'h00, "parity high");
        rc(8'h56, 1, 8'h02, "parity count");
        rc(8'h4D, 1, 8'h00, "parity cleared");
        // Mid-run reset with a pending flag and port 1 selected
        evt[0].ctrl_crc_evt <= 1'b1;
        i_rls_host.wr(8'h4C, 8'h13);
        evt[0] <= '0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        chk("reset select", 8'h00, {5'h00, rport, wen});
        rc(8'h4D, 1, 8'h00, "reset status");
        results();
    end
endmodule : rls_status_bank_test
